// file: design/dccc_buf2.v
// Two-entry valid/ready buffer for the activity word stream.
// Assumes a single clock and asynchronous active-low reset.
`include "dccc_defines.vh"

module dccc_buf2 (
	input wire pclk,
	input wire presetn,
	input wire [15:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [15:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [15:0] mem [0:1];
	reg wp;
	reg rp;
	reg [1:0] cnt;
	wire push;
	wire pop;

	assign in_ready = (cnt != 2'h2);
	assign out_valid = (cnt != 2'h0);
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
			mem[0] <= 16'h0000;
			mem[1] <= 16'h0000;
		end else begin
			if (push) begin
				mem[wp] <= in_data;
				wp <= ~wp;
			end
			if (pop)
				rp <= ~rp;
			if (push && !pop)
				cnt <= cnt + 2'h1;
			else if (pop && !push)
				cnt <= cnt - 2'h1;
		end
	end
endmodule // dccc_buf2

// file: design/dccc_defines.vh
// Constants for the DMA channel control and status block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef DCCC_DEFINES_VH
`define DCCC_DEFINES_VH

// ==================================================================
// Geometry
`define DCCC_NCH 8
`define DCCC_CHW 3

// ==================================================================
// Register byte offsets: channel control at 0x00 + 4*ch
`define DCCC_CTRL_BASE 12'h000
`define DCCC_STAT_OFF 12'h020
`define DCCC_LAST_OFF 12'h024
`define DCCC_DATA_OFF 12'h028

// ==================================================================
// Channel control fields
`define DCCC_B_ON 15
`define DCCC_B_SIZE 14
`define DCCC_B_DIR 13
`define DCCC_B_HALF 12
`define DCCC_B_NULL_WRITE_SELECT 11
`define DCCC_WMASK 16'hF833
`define DCCC_CTRL_RST 16'h0000

// ==================================================================
// Mode encodings
`define DCCC_OPM_CONT 2'h0
`define DCCC_OPM_ONE 2'h1
`define DCCC_OPM_CONT_PP 2'h2
`define DCCC_OPM_ONE_PP 2'h3

`endif

// file: design/dccc_top.v
// Per-channel control registers and controller status for an
// eight-channel DMA engine, reached over APB.
// Assumes transfer engine pulses come from logic on pclk.
//
// What this block does
// - Read-only 16-bit status shows channel of the most recent transfer.
// - Status shows each channel's ping-pong start offset selection.
// - Control bit 14 picks byte moves when one, word moves when zero.
// - Bit 13 one: buffer RAM to peripheral; zero: peripheral to RAM.
// - Bit 12 one: block interrupt at half block; zero: at end.
`include "dccc_defines.vh"

module dccc_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire xfer_done,
	input wire [2:0] xfer_chan,
	input wire [15:0] xfer_data,
	input wire block_done,
	input wire [2:0] block_chan,
	input wire half_done,
	input wire [2:0] half_chan,
	output reg [7:0] chan_on,
	output reg [7:0] size_byte,
	output reg [7:0] dir_to_periph,
	output reg [7:0] null_write_select,
	output reg [15:0] addressing_mode_select,
	output reg [15:0] op_mode,
	output reg [7:0] buf_sel,
	output reg [7:0] block_irq,
	output reg [15:0] act_data,
	output reg act_valid,
	input wire act_ready
);
	// ==============================================================
	// Register storage
	reg [15:0] channel_control [0:`DCCC_NCH-1];
	reg [15:0] last_channel_status;
	reg [2:0] last_chan;
	reg [7:0] pp_sel;
	reg [15:0] next_rd;
	reg next_err;
	wire access;
	wire wr_en;
	wire [15:0] status_word;
	wire buf_in_ready;
	wire [15:0] buf_out_data;
	wire buf_out_valid;
	wire buf_pop;

	// Decode a control register offset; returns 1 when hit
	function ctrl_hit;
		input [11:0] a;
		begin
			ctrl_hit = (a[11:5] == 7'h00) && (a[1:0] == 2'h0);
		end
	endfunction

	assign access = psel && penable && !pready;
	assign wr_en = access && pwrite;
	// Channel of last activity in 10-8, ping-pong bits 7-0
	assign status_word = {5'h00, last_chan, pp_sel};

	// ==============================================================
	// Control registers, one per channel
	genvar g;
	generate
		for (g = 0; g < `DCCC_NCH; g = g + 1) begin : g_ch
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					channel_control[g] <= `DCCC_CTRL_RST;
				end else if (wr_en && ctrl_hit(paddr) &&
					paddr[4:2] == g) begin
					// Unused bits never store, so they read as zero
					channel_control[g] <= pwdata[15:0] & `DCCC_WMASK;
				end
			end

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					chan_on[g] <= 1'b0;
					size_byte[g] <= 1'b0;
					dir_to_periph[g] <= 1'b0;
					null_write_select[g] <= 1'b0;
					addressing_mode_select[2*g+1:2*g] <= 2'h0;
					op_mode[2*g+1:2*g] <= 2'h0;
					buf_sel[g] <= 1'b0;
					block_irq[g] <= 1'b0;
				end else begin
					chan_on[g] <= channel_control[g][`DCCC_B_ON];
					size_byte[g] <= channel_control[g][`DCCC_B_SIZE];
					dir_to_periph[g] <= channel_control[g][`DCCC_B_DIR];
					null_write_select[g] <=
						channel_control[g][`DCCC_B_NULL_WRITE_SELECT];
					addressing_mode_select[2*g+1:2*g] <=
						channel_control[g][5:4];
					op_mode[2*g+1:2*g] <= channel_control[g][1:0];
					buf_sel[g] <= pp_sel[g];
					// One-cycle interrupt at half or full block
					if (channel_control[g][`DCCC_B_HALF])
						block_irq[g] <= chan_on[g] && half_done &&
							half_chan == g;
					else
						block_irq[g] <= chan_on[g] && block_done &&
							block_chan == g;
				end
			end

			// Ping-pong toggles after each block in modes 2 and 3
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pp_sel[g] <= 1'b0;
				end else if (!channel_control[g][`DCCC_B_ON]) begin
					// Disabled channel restarts on the primary offset
					pp_sel[g] <= 1'b0;
				end else if (block_done && block_chan == g &&
					channel_control[g][1]) begin
					pp_sel[g] <= ~pp_sel[g];
				end
			end
		end
	endgenerate

	// ==============================================================
	// Most recently active channel
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_chan <= 3'h0;
			last_channel_status <= 16'h0000;
		end else begin
			if (xfer_done)
				last_chan <= xfer_chan;
			last_channel_status <= status_word;
		end
	end

	// ==============================================================
	// Activity words; a stalled consumer holds up to three (two here, one in act_data)
	dccc_buf2 u_buf (
		.pclk(pclk),
		.presetn(presetn),
		.in_data(xfer_data),
		.in_valid(xfer_done),
		.in_ready(buf_in_ready),
		.out_data(buf_out_data),
		.out_valid(buf_out_valid),
		.out_ready(buf_pop)
	);

	// Output stage is a register so the buffer drains into it
	assign buf_pop = buf_out_valid && (!act_valid || act_ready);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_valid <= 1'b0;
			act_data <= 16'h0000;
		end else if (buf_pop) begin
			act_valid <= 1'b1;
			act_data <= buf_out_data;
		end else if (act_ready) begin
			act_valid <= 1'b0;
		end
	end

	// ==============================================================
	// APB read decode and answer
	always @* begin
		next_rd = 16'h0000;
		next_err = 1'b0;
		if (ctrl_hit(paddr)) begin
			next_rd = channel_control[paddr[4:2]];
		end else if (paddr == `DCCC_STAT_OFF) begin
			next_rd = last_channel_status;
			next_err = pwrite; // Read-only
		end else if (paddr == `DCCC_LAST_OFF) begin
			next_rd = {13'h0000, last_chan};
			next_err = pwrite;
		end else if (paddr == `DCCC_DATA_OFF) begin
			next_rd = {15'h0000, buf_in_ready};
			next_err = pwrite;
		end else begin
			next_err = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (access) begin
			pready <= 1'b1;
			pslverr <= next_err;
			prdata <= pwrite ? 32'h00000000 : {16'h0000, next_rd};
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule // dccc_top

// file: tb/dccc_periph.sv
// Transfer engine and receiving peripheral beside the block.
// Assumes pclk; stall holds off the receiver to fill the buffer.
module dccc_periph (
	input wire pclk,
	output logic xfer_done,
	output logic [2:0] xfer_chan,
	output logic [15:0] xfer_data,
	output logic block_done,
	output logic [2:0] block_chan,
	output logic half_done,
	output logic [2:0] half_chan,
	output logic act_ready,
	input wire [15:0] act_data,
	input wire act_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic stall = 1'b0;
	logic [15:0] got[$];
	initial {xfer_done, xfer_chan, xfer_data, block_done} = '0;
	initial {block_chan, half_done, half_chan, act_ready} = '0;
	// ==========
	// One-cycle engine pulse; data line flips once released
	task pulse(input logic [2:0] k, input logic [2:0] c,
		input logic [15:0] d);
		@(posedge pclk);
		{half_done, block_done, xfer_done} <= k;
		{half_chan, block_chan, xfer_chan} <= {c, c, c};
		xfer_data <= d;
		@(posedge pclk);
		{half_done, block_done, xfer_done} <= 3'h0;
		xfer_data <= ~d;
	endtask
	always @(posedge pclk) begin
		act_ready <= !stall;
		if (act_valid && act_ready) got.push_back(act_data);
	end
endmodule // dccc_periph

// file: tb/dccc_sva.sv
// Port assertions for the DMA channel control block.
// Assumes one pclk domain with asynchronous active-low presetn.
module dccc_sva (
	input wire pclk,
	input wire presetn,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire block_done,
	input wire [2:0] block_chan,
	input wire half_done,
	input wire [7:0] chan_on,
	input wire [7:0] size_byte,
	input wire [7:0] dir_to_periph,
	input wire [7:0] buf_sel,
	input wire [7:0] block_irq,
	input wire [15:0] act_data,
	input wire act_valid,
	input wire act_ready
);
	// ==========
	// Relations
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ro; pready && pwrite && paddr == 12'h020 |-> pslverr;
	endproperty
	a_ro: assert property (p_ro) else $error("status took write");
	property p_pad; pready && !pwrite && paddr < 12'h020 |->
		(prdata & 32'hFFFF07CC) == 32'h0; endproperty
	a_pad: assert property (p_pad) else $error("unused bit set");
	property p_on; block_irq[3] |-> $past(chan_on[3]); endproperty
	a_on: assert property (p_on) else $error("irq while off");
	property p_why; block_irq[3] |-> $past(block_done || half_done);
	endproperty
	a_why: assert property (p_why) else $error("irq no cause");
	property p_pp; $rose(buf_sel[3]) |->
		$past(block_done && block_chan == 3'h3, 2); endproperty
	a_pp: assert property (p_pp) else $error("bad toggle");
	property p_cfg; size_byte != $past(size_byte) ||
		dir_to_periph != $past(dir_to_periph) |->
		$past(pwrite && pready) || $past(pwrite && pready, 2); endproperty
	a_cfg: assert property (p_cfg) else $error("cfg moved");
	property p_hold; act_valid && !act_ready |=>
		act_valid && $stable(act_data); endproperty
	a_hold: assert property (p_hold) else $error("word lost");
endmodule // dccc_sva
bind dccc_top dccc_sva sva_u (.pclk, .presetn, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .block_done, .block_chan, .half_done,
	.chan_on, .size_byte, .dir_to_periph, .buf_sel, .block_irq,
	.act_data, .act_valid, .act_ready);

// file: tb/dccc_top_tb.sv
// Self-checking bench for the DMA channel control block over APB.
// Assumes the partner model and the bound checker.
module dccc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, xfer_done, block_done, half_done;
	logic act_ready, act_valid;
	logic [2:0] xfer_chan, block_chan, half_chan;
	logic [15:0] xfer_data, act_data, addressing_mode_select, op_mode;
	logic [7:0] chan_on, size_byte, dir_to_periph, null_write_select;
	logic [7:0] buf_sel, block_irq;
	int miscompares = 0;
	int n_compared = 0;
	int nirq = 0;
	always #10 pclk = ~pclk;
	always @(posedge pclk) nirq += block_irq[3];
	dccc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .xfer_done, .xfer_chan,
		.xfer_data, .block_done, .block_chan, .half_done, .half_chan,
		.chan_on, .size_byte, .dir_to_periph, .null_write_select,
		.addressing_mode_select, .op_mode, .buf_sel, .block_irq,
		.act_data, .act_valid, .act_ready);
	dccc_periph periph_u (.pclk, .xfer_done, .xfer_chan, .xfer_data,
		.block_done, .block_chan, .half_done, .half_chan, .act_ready,
		.act_data, .act_valid);
	// ==========
	// Bus access, compare and verdict
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			$display("ERROR %0t: no pready", $time);
		end
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		finish_test;
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int c = 0; c < 9; c++) begin
			apb(0, 12'(4 * c), 0);
			chk(rd, 0);
		end
		apb(1, 12'h00C, 32'hFFFF);
		apb(0, 12'h00C, 0);
		chk(rd, 32'hF833);
		chk({chan_on[3], size_byte[3], dir_to_periph[3]}, 7);
		chk({null_write_select[3], addressing_mode_select[7:6],
			op_mode[7:6]}, 5'h1F);
		apb(1, 12'h020, 32'hFFFF);
		chk(er, 1);
		apb(0, 12'h030, 0);
		chk(er, 1);
		$display("register test done");
		periph_u.stall <= 1'b1;
		for (int i = 0; i < 3; i++) periph_u.pulse(1, 3, 16'hA5C0 + 16'(i));
		apb(0, 12'h028, 0);
		chk(rd, 0);
		periph_u.stall <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(periph_u.got.size(), 3);
		for (int i = 0; i < 3; i++) chk(periph_u.got[i], 16'hA5C0 + 16'(i));
		apb(0, 12'h024, 0);
		chk(rd, 3);
		$display("stream test done");
		periph_u.pulse(2, 3, 0);
		periph_u.pulse(4, 3, 0);
		apb(0, 12'h020, 0);
		chk(nirq, 1);
		chk(rd, 32'h308);
		apb(1, 12'h00C, 32'h8000);
		periph_u.pulse(2, 3, 0);
		periph_u.pulse(4, 3, 0);
		apb(1, 12'h00C, 0);
		periph_u.pulse(2, 3, 0);
		repeat (3) @(posedge pclk);
		chk(nirq, 2);
		chk(buf_sel[3], 0);
		$display("ping-pong test done");
		finish_test;
	end
endmodule // dccc_top_tb
